//--- logic/rate_regs_pkg.sv
`default_nettype none
package rate_regs_pkg;
  // ----------------------------------------------------------------
  // Register identity strings (address, select bits, read/write bit)
  // ----------------------------------------------------------------
  localparam logic [7:0] ID_REF_DIVIDER   = 8'h94;
  localparam logic [7:0] ID_FEEDBACK_MULT = 8'ha4;
  localparam logic [7:0] ID_RATE_SELECT   = 8'hb4;
  localparam logic [7:0] ID_PRECOMP_THR   = 8'hc4;
  localparam logic [2:0] SELECT_BITS      = 3'h2;
  localparam logic       RW_WRITE         = 1'b0;
  localparam logic       RW_READ          = 1'b1;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DEFECT_SCAN_BIT   = 7;
  localparam int STROBE_POL_BIT    = 7;
  localparam int QUALITY_FRZ_BIT   = 4;
  localparam int THRESH_TC_MSB     = 7;
  localparam int THRESH_TC_LSB     = 6;
  localparam int PRECOMP_MSB       = 3;

  // ----------------------------------------------------------------
  // Reset values (the device leaves them undefined; zero chosen)
  // ----------------------------------------------------------------
  localparam logic [7:0] REF_DIVIDER_RST   = 8'h00;
  localparam logic [7:0] FEEDBACK_MULT_RST = 8'h00;
  localparam logic [7:0] RATE_SELECT_RST   = 8'h00;
  localparam logic [7:0] PRECOMP_THR_RST   = 8'h00;

  // ----------------------------------------------------------------
  // Legal ranges for the controller side
  // ----------------------------------------------------------------
  localparam logic [6:0] REF_DIV_MIN  = 7'h02;
  localparam logic [6:0] REF_DIV_MAX  = 7'h7f;
  localparam logic [7:0] FB_MULT_MIN  = 8'h02;
  localparam logic [7:0] FB_MULT_MAX  = 8'hff;
  localparam logic [6:0] RATE_MIN     = 7'h25;
  localparam logic [6:0] RATE_MAX     = 7'h7f;

  // ----------------------------------------------------------------
  // Timing: serial clock half period and threshold time constants
  // ----------------------------------------------------------------
  localparam int CLK_NS          = 50;
  localparam int SER_HALF_NS     = 100;
  localparam int SER_HALF_CYC    = (SER_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int TC_STEP_NS      = 200;
  localparam int TC_STEP_CYC     = (TC_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int FRAME_BITS      = 16;

  // Precompensation magnitude per code, tenths of a percent
  localparam logic [9:0] PRECOMP_PERMILLE [16] = '{
    10'h000, 10'h015, 10'h02a, 10'h03f, 10'h054, 10'h069, 10'h07e, 10'h093,
    10'h0a8, 10'h0bd, 10'h0d2, 10'h0e7, 10'h0fa, 10'h111, 10'h126, 10'h13b};
endpackage
`default_nettype wire

//--- logic/serial_port_if.sv
`timescale 1ns/1ns
`default_nettype none
// Three-wire serial port: enable, clock, two-way data
interface serial_port_if;
  logic sp_enable;       // Frame enable, high during a transfer
  logic sp_clock;        // Serial clock, data sampled on rise
  logic ctl_data_out;    // Controller data drive
  logic ctl_data_oe;     // Controller drive enable
  logic dev_data_out;    // Device data drive
  logic dev_data_oe;     // Device drive enable
  wire  sp_data = dev_data_oe ? dev_data_out : (ctl_data_oe ? ctl_data_out : 1'b1);

  modport controller (
    output sp_enable,
    output sp_clock,
    output ctl_data_out,
    output ctl_data_oe,
    input  sp_data
  );
  modport device (
    input  sp_enable,
    input  sp_clock,
    output dev_data_out,
    output dev_data_oe,
    input  sp_data
  );
endinterface
`default_nettype wire

//--- logic/rate_regs_device.sv
// Operation
// - 0x94 reference divider, 0xa4 feedback multiplier
// - 0xb4 data rate, 0xc4 precomp/threshold
// - Reference bit 7 enables defect scan
// - Reference divider count 2 to 127
// - Feedback count 2 to 255
// - Synth frequency reference*(fb+1)/(ref+1)
// - Rate bit 7 sets strobe polarity
// - Rate setting 37 to 127
// - Bits 7-6 threshold constant 200-800 ns
// - Bit 4 freezes quality at sync
// - Bits 3-0 precomp shift per table
`timescale 1ns/1ns
`default_nettype none
module rate_regs_device
  import rate_regs_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // Serial port
  serial_port_if.device   sp,
  // Channel status inputs
  input  wire logic       read_gate,
  input  wire logic       sync_byte_detect,
  input  wire logic       sync_field_count,
  input  wire logic       servo_strobe_raw,
  // Decoded settings
  output logic            defect_scan_on,
  output logic [6:0]      ref_divider_count,
  output logic [7:0]      feedback_multiplier_count,
  output logic [8:0]      synth_num,
  output logic [7:0]      synth_den,
  output logic            servo_read_strobe,
  output logic [6:0]      rate_setting,
  output logic [1:0]      level_threshold_time_const,
  output logic [4:0]      threshold_cycles,
  output logic            threshold_active,
  output logic            quality_update_en,
  output logic [3:0]      precomp_setting,
  output logic [9:0]      precomp_permille,
  output logic            write_done
);
  // --------------------------------------------------------------
  // Serial receive
  // --------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_ID = 2'b01, S_DATA = 2'b11} sp_state_t;
  sp_state_t   state_reg;      // Frame phase
  logic [3:0]  bit_cnt_reg;    // Bits left in current byte
  logic [7:0]  id_reg;         // Received identity string
  logic [7:0]  shift_reg;      // Data shifter
  logic        clk_d_reg;      // Previous serial clock
  logic [7:0]  ref_reg;        // ref_divider_reg
  logic [7:0]  fb_reg;         // feedback_multiplier_reg
  logic [7:0]  rate_reg;       // rate_select_reg
  logic [7:0]  pcmp_reg;       // precomp_threshold_reg
  logic        frozen_reg;     // Quality frozen since sync byte

  wire sclk_rise = sp.sp_clock & ~clk_d_reg;   // Sample edge
  wire sclk_fall = ~sp.sp_clock & clk_d_reg;   // Drive edge
  wire id_last   = (state_reg == S_ID) & sclk_rise & (bit_cnt_reg == 4'h0);
  // Write commits only when the frame ends with a full data byte
  wire frame_end = (state_reg == S_DATA) & ~sp.sp_enable & (bit_cnt_reg == 4'hf);
  wire [7:0] id_wr = {id_reg[7:1], RW_WRITE};
  wire is_read   = id_reg[0] == RW_READ;
  wire rd_shift  = (state_reg == S_DATA) & is_read & sclk_fall;  // Device drive edge

  // Register selection
  wire sel_ref  = id_wr == ID_REF_DIVIDER;
  wire sel_fb   = id_wr == ID_FEEDBACK_MULT;
  wire sel_rate = id_wr == ID_RATE_SELECT;
  wire sel_pcmp = id_wr == ID_PRECOMP_THR;
  wire [7:0] rd_word = sel_ref ? ref_reg : sel_fb ? fb_reg :
                       sel_rate ? rate_reg : sel_pcmp ? pcmp_reg : 8'h00;

  // --------------------------------------------------------------
  // Frame sequencing
  // --------------------------------------------------------------
  // Sample clock history
  always_ff @(posedge core_clk or posedge reset)
    if (reset) clk_d_reg <= 1'b0;
    else       clk_d_reg <= sp.sp_clock;

  // Phase and bit counting; enable low aborts any frame
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg   <= S_IDLE;
      bit_cnt_reg <= 4'h7;
    end
    else if (!sp.sp_enable)
    begin
      state_reg   <= S_IDLE;
      bit_cnt_reg <= 4'h7;
    end
    else
    begin
      unique case (state_reg)
        S_IDLE:  state_reg <= S_ID;
        S_ID:    if (id_last) state_reg <= S_DATA;
        S_DATA:  ;
      endcase
      if (sclk_rise && state_reg != S_IDLE)
        bit_cnt_reg <= (bit_cnt_reg == 4'h0) ? ((state_reg == S_ID) ? 4'h7 : 4'hf)
                                             : (bit_cnt_reg == 4'hf ? 4'hf : bit_cnt_reg - 4'h1);
    end
  end

  // Identity then data shift, MSB first
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      id_reg    <= 8'h00;
      shift_reg <= 8'h00;
    end
    else if (sclk_rise && state_reg == S_ID)
      id_reg <= {id_reg[6:0], sp.sp_data};
    else if (sclk_rise && state_reg == S_DATA && bit_cnt_reg != 4'hf)
      shift_reg <= {shift_reg[6:0], sp.sp_data};
  end

  // Read data driven on falling serial clock. The first bit waits for the
  // fall after the R/W bit, once the controller has let go of the line.
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      sp.dev_data_oe  <= 1'b0;
      sp.dev_data_out <= 1'b0;
    end
    else if (!sp.sp_enable)
      sp.dev_data_oe <= 1'b0;                        // Cut or ended frame
    else if (rd_shift)
    begin
      // Release after the last bit so the line is free before enable drops
      sp.dev_data_oe  <= (bit_cnt_reg != 4'hf);
      sp.dev_data_out <= rd_word[bit_cnt_reg[2:0]];
    end
  end

  // --------------------------------------------------------------
  // Register bank
  // --------------------------------------------------------------
  // Held until rewritten; values commit only at frame end
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      ref_reg  <= REF_DIVIDER_RST;
      fb_reg   <= FEEDBACK_MULT_RST;
      rate_reg <= RATE_SELECT_RST;
      pcmp_reg <= PRECOMP_THR_RST;
    end
    else if (frame_end && !is_read)
    begin
      if (sel_ref)  ref_reg  <= shift_reg;
      if (sel_fb)   fb_reg   <= shift_reg;
      if (sel_rate) rate_reg <= shift_reg;
      if (sel_pcmp) pcmp_reg <= shift_reg;
    end
  end

  // Quality freeze latch, set wins over the read-gate clear
  always_ff @(posedge core_clk or posedge reset)
    if (reset)                                     frozen_reg <= 1'b0;
    else if (sync_byte_detect && pcmp_reg[QUALITY_FRZ_BIT]) frozen_reg <= 1'b1;
    else if (!read_gate)                           frozen_reg <= 1'b0;

  // --------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------
  wire [1:0] tc_code = pcmp_reg[THRESH_TC_MSB:THRESH_TC_LSB];
  // Five bits: the longest constant is sixteen clocks
  wire [4:0] tc_cyc  = 5'((32'(tc_code) + 1) * TC_STEP_CYC);
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      defect_scan_on             <= 1'b0;
      ref_divider_count          <= 7'h00;
      feedback_multiplier_count  <= 8'h00;
      synth_num                  <= 9'h000;
      synth_den                  <= 8'h00;
      servo_read_strobe          <= 1'b1;
      rate_setting               <= 7'h00;
      level_threshold_time_const <= 2'h0;
      threshold_cycles           <= 5'h00;
      threshold_active           <= 1'b0;
      quality_update_en          <= 1'b0;
      precomp_setting            <= 4'h0;
      precomp_permille           <= 10'h000;
      write_done                 <= 1'b0;
    end
    else
    begin
      defect_scan_on             <= ref_reg[DEFECT_SCAN_BIT];
      ref_divider_count          <= ref_reg[6:0];
      feedback_multiplier_count  <= fb_reg;
      synth_num                  <= {1'b0, fb_reg} + 9'h001;
      synth_den                  <= {1'b0, ref_reg[6:0]} + 8'h01;
      // Polarity 0 gives active-low strobe
      servo_read_strobe          <= rate_reg[STROBE_POL_BIT] ? servo_strobe_raw
                                                             : ~servo_strobe_raw;
      rate_setting               <= rate_reg[6:0];
      level_threshold_time_const <= tc_code;
      threshold_cycles           <= tc_cyc;
      threshold_active           <= read_gate & sync_field_count;
      quality_update_en          <= read_gate & ~frozen_reg;
      precomp_setting            <= pcmp_reg[PRECOMP_MSB:0];
      precomp_permille           <= PRECOMP_PERMILLE[pcmp_reg[PRECOMP_MSB:0]];
      write_done                 <= frame_end & ~is_read;
    end
  end
endmodule
`default_nettype wire

//--- logic/rate_regs_controller.sv
`timescale 1ns/1ns
`default_nettype none
module rate_regs_controller
  import rate_regs_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // User request
  input  wire logic       req_valid,
  input  wire logic       req_read,
  input  wire logic [7:0] req_id,
  input  wire logic [7:0] req_data,
  output logic            req_ready,
  output logic            rsp_valid,
  output logic [7:0]      rsp_data,
  output logic            req_range_err,
  // Serial port
  serial_port_if.controller sp
);
  // --------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------
  typedef enum logic [1:0] {C_IDLE = 2'b00, C_SHIFT = 2'b01, C_END = 2'b11} c_state_t;
  c_state_t    state_reg;    // Transfer phase
  logic [15:0] frame_reg;    // Id and data, MSB first
  logic [4:0]  bits_reg;     // Bits left
  logic [3:0]  div_reg;      // Half-period divider
  logic        rd_reg;       // Current transfer is a read
  logic [7:0]  cap_reg;      // Captured read data

  // Range check on written counts, select-bit check on written identities
  wire [7:0] id_w = {req_id[7:1], RW_WRITE};
  wire bad_ref  = id_w == ID_REF_DIVIDER && (req_data[6:0] < REF_DIV_MIN);
  wire bad_fb   = id_w == ID_FEEDBACK_MULT && (req_data < FB_MULT_MIN);
  wire bad_rate = id_w == ID_RATE_SELECT && (req_data[6:0] < RATE_MIN);
  wire bad_id   = req_id[3:1] != SELECT_BITS;
  wire reject   = !req_read && (bad_ref || bad_fb || bad_rate || bad_id);
  wire tick     = div_reg == 4'(SER_HALF_CYC - 1);

  // Transfer engine; one half period per tick
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg       <= C_IDLE;
      frame_reg       <= 16'h0000;
      bits_reg        <= 5'h00;
      div_reg         <= 4'h0;
      rd_reg          <= 1'b0;
      cap_reg         <= 8'h00;
      req_ready       <= 1'b1;
      rsp_valid       <= 1'b0;
      rsp_data        <= 8'h00;
      req_range_err   <= 1'b0;
      sp.sp_enable    <= 1'b0;
      sp.sp_clock     <= 1'b0;
      sp.ctl_data_out <= 1'b0;
      sp.ctl_data_oe  <= 1'b0;
    end
    else
    begin
      rsp_valid     <= 1'b0;
      req_range_err <= 1'b0;
      div_reg       <= tick ? 4'h0 : div_reg + 4'h1;
      unique case (state_reg)
        C_IDLE:
          if (req_valid && reject)
            req_range_err <= 1'b1;
          else if (req_valid)
          begin
            frame_reg       <= {req_id[7:1], req_read, req_data};
            rd_reg          <= req_read;
            bits_reg        <= 5'(FRAME_BITS);
            req_ready       <= 1'b0;
            sp.sp_enable    <= 1'b1;
            sp.ctl_data_oe  <= 1'b1;
            sp.ctl_data_out <= req_id[7];
            div_reg         <= 4'h0;
            state_reg       <= C_SHIFT;
          end
        C_SHIFT:
          if (tick)
          begin
            sp.sp_clock <= ~sp.sp_clock;
            if (sp.sp_clock)
            begin
              // Falling edge: next bit out
              frame_reg       <= {frame_reg[14:0], 1'b0};
              sp.ctl_data_out <= frame_reg[14];
              // Read: let go right after the R/W bit has been sampled
              if (bits_reg == 5'h09 && rd_reg) sp.ctl_data_oe <= 1'b0;
              if (bits_reg == 5'h01) state_reg <= C_END;
              bits_reg <= bits_reg - 5'h01;
            end
            else if (bits_reg <= 5'h08)
              cap_reg <= {cap_reg[6:0], sp.sp_data};
          end
        C_END:
          if (tick)
          begin
            sp.sp_enable   <= 1'b0;
            sp.ctl_data_oe <= 1'b0;
            rsp_valid      <= 1'b1;
            rsp_data       <= cap_reg;
            req_ready      <= 1'b1;
            state_reg      <= C_IDLE;
          end
        default: state_reg <= C_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- verif/rate_regs_sva.sv
`timescale 1ns/1ns
`default_nettype none
module rate_regs_sva
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // Serial port wires
  input  wire logic sp_enable,
  input  wire logic sp_clock,
  input  wire logic ctl_data_out,
  input  wire logic ctl_data_oe,
  input  wire logic dev_data_out,
  input  wire logic dev_data_oe,
  input  wire logic sp_data
);
  import rate_regs_pkg::*;
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic       clk_q;     // Serial clock one cycle back
  logic [4:0] rise_cnt;  // Serial clock rises in this frame
  logic [7:0] id_sh;     // Identity bits as seen on the wire
  wire        clk_rise = sp_clock & ~clk_q;
  // Count rises per frame, capture the identity byte
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      clk_q    <= 1'b0;
      rise_cnt <= 5'h00;
      id_sh    <= 8'h00;
    end
    else
    begin
      clk_q <= sp_clock;
      if (!sp_enable)
        rise_cnt <= 5'h00;     // Frame over, start afresh
      else if (clk_rise)
        rise_cnt <= rise_cnt + 5'h01;
      if (sp_enable && clk_rise && rise_cnt < 5'h08)
        id_sh <= {id_sh[6:0], sp_data};
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_clk_idle;
    !sp_enable |-> !sp_clock;
  endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("serial clock runs outside frame");
  property p_frame_start;
    $rose(sp_enable) |-> ctl_data_oe && !sp_clock;
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame start malformed");
  property p_clk_half;
    $rose(sp_clock) |-> sp_clock [*2] ##1 !sp_clock;
  endproperty
  a_clk_half: assert property (p_clk_half) else $error("serial clock high time wrong");
  // Data must not move while the device may sample it
  property p_data_hold;
    sp_clock && $past(sp_clock) && ctl_data_oe |-> $stable(ctl_data_out);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved while clock high");
  property p_frame_bits;
    $fell(sp_enable) |-> rise_cnt == 5'h10;
  endproperty
  a_frame_bits: assert property (p_frame_bits) else $error("frame is not sixteen bits");
  property p_select;
    $rose(rise_cnt == 5'h08) |-> id_sh[3:1] == SELECT_BITS;
  endproperty
  a_select: assert property (p_select) else $error("select bits on wire wrong");
  property p_one_driver;
    !(ctl_data_oe && dev_data_oe);
  endproperty
  a_one_driver: assert property (p_one_driver) else $error("both ends drive data");
  property p_dev_quiet;
    dev_data_oe |-> sp_enable && rise_cnt >= 5'h08;
  endproperty
  a_dev_quiet: assert property (p_dev_quiet) else $error("device drives outside data phase");
  property p_ctl_release;
    !sp_enable |-> !ctl_data_oe;
  endproperty
  a_ctl_release: assert property (p_ctl_release) else $error("controller drives when idle");
endmodule
`default_nettype wire

//--- verif/read_channel_rate_precomp_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module read_channel_rate_precomp_regs_tb_top;
  import rate_regs_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic       core_clk  = 1'b0;  // 20 MHz
  logic       reset     = 1'b1;  // Held for 10 cycles
  logic       req_valid = 1'b0;
  logic       req_read  = 1'b0;
  logic [7:0] req_id    = 8'h00;
  logic [7:0] req_data  = 8'h00;
  logic       read_gate = 1'b0;
  logic       sync_byte_detect = 1'b0;
  logic       sync_field_count = 1'b0;
  logic       servo_strobe_raw = 1'b0;
  logic       req_ready, rsp_valid, req_range_err, defect_scan_on, servo_read_strobe;
  logic       threshold_active, quality_update_en, write_done;
  logic [7:0] rsp_data, feedback_multiplier_count, synth_den;
  logic [6:0] ref_divider_count, rate_setting;
  logic [8:0] synth_num;
  logic [4:0] threshold_cycles;
  logic [3:0] precomp_setting;
  logic [1:0] level_threshold_time_const;
  logic [9:0] precomp_permille;
  int         fails, total_checks, cycles, done_cnt, exp_done;
  logic       got_err;           // Refusal seen on last request
  logic [7:0] rdata;             // Data of last response
  // ----------------------------------------
  // Clock, design ends and checker
  // ----------------------------------------
  always #25 core_clk = ~core_clk;
  serial_port_if sp_bus ();
  rate_regs_controller u_rate_regs_controller (.core_clk(core_clk), .reset(reset),
    .req_valid(req_valid), .req_read(req_read), .req_id(req_id), .req_data(req_data),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .req_range_err(req_range_err), .sp(sp_bus));
  rate_regs_device u_rate_regs_device (.core_clk(core_clk), .reset(reset), .sp(sp_bus),
    .read_gate(read_gate), .sync_byte_detect(sync_byte_detect),
    .sync_field_count(sync_field_count), .servo_strobe_raw(servo_strobe_raw),
    .defect_scan_on(defect_scan_on), .ref_divider_count(ref_divider_count),
    .feedback_multiplier_count(feedback_multiplier_count), .synth_num(synth_num),
    .synth_den(synth_den), .servo_read_strobe(servo_read_strobe),
    .rate_setting(rate_setting), .level_threshold_time_const(level_threshold_time_const),
    .threshold_cycles(threshold_cycles), .threshold_active(threshold_active),
    .quality_update_en(quality_update_en), .precomp_setting(precomp_setting),
    .precomp_permille(precomp_permille), .write_done(write_done));
  rate_regs_sva u_rate_regs_sva (.core_clk(core_clk), .reset(reset),
    .sp_enable(sp_bus.sp_enable), .sp_clock(sp_bus.sp_clock),
    .ctl_data_out(sp_bus.ctl_data_out), .ctl_data_oe(sp_bus.ctl_data_oe),
    .dev_data_out(sp_bus.dev_data_out), .dev_data_oe(sp_bus.dev_data_oe),
    .sp_data(sp_bus.sp_data));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One request, waits for the answer or the refusal
  task automatic do_req(input logic rd, input logic [7:0] id, input logic [7:0] dat);
    while (req_ready !== 1'b1)
      @(posedge core_clk);
    req_read  <= rd;
    req_id    <= id;
    req_data  <= dat;
    req_valid <= 1'b1;
    @(posedge core_clk);
    req_valid <= 1'b0;
    repeat (200)
    begin
      @(posedge core_clk);
      if (rsp_valid === 1'b1 || req_range_err === 1'b1)
        break;
    end
    got_err = req_range_err;
    rdata   = rsp_data;
    chk("answer", 10'h001, {9'h000, rsp_valid | req_range_err});
    if (!rd && got_err !== 1'b1)
      exp_done++;
    repeat (4) @(posedge core_clk);   // Let write_done and settings land
  endtask
  // Counts device completion pulses
  always @(posedge core_clk)
    if (write_done === 1'b1)
      done_cnt++;
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_ref_div;
    do_req(1'b0, ID_REF_DIVIDER, 8'h82);
    chk("defect_scan_on", 10'h001, {9'h000, defect_scan_on});
    chk("ref_divider_count", 10'h002, {3'h0, ref_divider_count});
    chk("synth_den", 10'h003, {2'h0, synth_den});
    do_req(1'b0, ID_REF_DIVIDER, 8'h7f);
    chk("defect_scan_on", 10'h000, {9'h000, defect_scan_on});
    chk("ref_divider_count", 10'h07f, {3'h0, ref_divider_count});
    chk("synth_den", 10'h080, {2'h0, synth_den});
  endtask
  task automatic t_fb_mult;
    do_req(1'b0, ID_FEEDBACK_MULT, 8'hff);
    chk("synth_num", 10'h100, {1'b0, synth_num});
    do_req(1'b0, ID_FEEDBACK_MULT, 8'h02);
    chk("fb_count", 10'h002, {2'h0, feedback_multiplier_count});
    chk("synth_num", 10'h003, {1'b0, synth_num});
    do_req(1'b1, ID_FEEDBACK_MULT | 8'h01, 8'h00);
    chk("read data", 10'h002, {2'h0, rdata});
    chk("synth_den held", 10'h080, {2'h0, synth_den});
  endtask
  task automatic t_rate;
    do_req(1'b0, ID_RATE_SELECT, 8'ha5);
    chk("rate_setting", 10'h025, {3'h0, rate_setting});
    servo_strobe_raw <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("strobe high pol", 10'h001, {9'h000, servo_read_strobe});
    do_req(1'b0, ID_RATE_SELECT, 8'h7f);
    chk("rate_setting", 10'h07f, {3'h0, rate_setting});
    chk("strobe low pol", 10'h000, {9'h000, servo_read_strobe});
    servo_strobe_raw <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("strobe low pol", 10'h001, {9'h000, servo_read_strobe});
  endtask
  // Every precomp code, threshold codes cycled alongside
  task automatic t_precomp;
    logic [3:0] c;
    for (int i = 0; i < 16; i++)
    begin
      c = i[3:0];
      do_req(1'b0, ID_PRECOMP_THR, {c[1:0], 2'b00, c});
      chk("precomp_setting", {6'h00, c}, {6'h00, precomp_setting});
      chk("precomp_permille", (c == 4'hc) ? 10'h0fa : {6'h00, c} * 10'h015,
          precomp_permille);
      chk("tc code", {8'h00, c[1:0]}, {8'h00, level_threshold_time_const});
      chk("tc cycles", 10'(({8'h00, c[1:0]} + 10'h001) * TC_STEP_CYC),
          {5'h00, threshold_cycles});
    end
  endtask
  task automatic t_freeze;
    do_req(1'b0, ID_PRECOMP_THR, 8'h10);
    read_gate <= 1'b1;
    @(posedge core_clk);
    sync_byte_detect <= 1'b1;
    @(posedge core_clk);
    sync_byte_detect <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("frozen", 10'h000, {9'h000, quality_update_en});
    chk("thr before count", 10'h000, {9'h000, threshold_active});
    read_gate <= 1'b0;
    do_req(1'b0, ID_PRECOMP_THR, 8'h00);
    read_gate <= 1'b1;
    sync_byte_detect <= 1'b1;
    sync_field_count <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("updating", 10'h001, {9'h000, quality_update_en});
    chk("threshold_active", 10'h001, {9'h000, threshold_active});
    sync_byte_detect <= 1'b0;
    sync_field_count <= 1'b0;
    read_gate <= 1'b0;
    chk("write_done count", exp_done[9:0], done_cnt[9:0]);
  endtask
  // Out-of-range counts, bad select bits, unknown identity
  task automatic t_refused;
    do_req(1'b0, ID_REF_DIVIDER, 8'h01);
    chk("ref refused", 10'h001, {9'h000, got_err});
    do_req(1'b0, ID_RATE_SELECT, 8'h24);
    chk("rate refused", 10'h001, {9'h000, got_err});
    do_req(1'b0, ID_FEEDBACK_MULT, 8'h01);
    chk("fb refused", 10'h001, {9'h000, got_err});
    do_req(1'b0, 8'h9c, 8'h05);
    chk("select refused", 10'h001, {9'h000, got_err});
    do_req(1'b0, 8'hd4, 8'h55);
    chk("ref kept", 10'h07f, {3'h0, ref_divider_count});
    chk("fb kept", 10'h002, {2'h0, feedback_multiplier_count});
    chk("rate kept", 10'h07f, {3'h0, rate_setting});
    chk("precomp kept", 10'h000, {6'h00, precomp_setting});
    do_req(1'b1, ID_REF_DIVIDER | 8'h01, 8'h00);
    chk("ref read back", 10'h07f, {2'h0, rdata});
    do_req(1'b1, ID_RATE_SELECT | 8'h01, 8'h00);
    chk("rate read back", 10'h07f, {2'h0, rdata});
  endtask
  // ----------------------------------------
  // Closing report and run control
  // ----------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard, runs are about 2100 cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      results();
    end
  end
  initial
  begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_ref_div();
    t_fb_mult();
    t_rate();
    t_precomp();
    t_freeze();
    t_refused();
    results();
  end
endmodule
`default_nettype wire
